// ---- gio_pkg.sv ----
package gio_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int GIO_GROUPS = 5;
  localparam int GIO_WIDTH = 32;
  localparam int GIO_LINES = GIO_GROUPS * GIO_WIDTH;
  localparam int GIO_ADDR_W = 12;
  localparam int GIO_FLAG_BIT = 31;

  // ---------------------------------------------------------------
  // register map, group g at base + 4*g
  // ---------------------------------------------------------------
  localparam logic [11:0] GIO_ALT_WE_BASE = 12'h200;
  localparam logic [11:0] GIO_ALT_DATA_BASE = 12'h220;
  localparam logic [11:0] GIO_MUX_BASE = 12'h240;
  localparam logic [11:0] GIO_POL_BASE = 12'h260;
  localparam logic [11:0] GIO_OUT_BASE = 12'h280;
  localparam logic [11:0] GIO_IN_BASE = 12'h300;
  localparam logic [11:0] GIO_IN_100_OFS = 12'h308;

  // ---------------------------------------------------------------
  // reset values and implemented lines per group
  // ---------------------------------------------------------------
  localparam logic [31:0] GIO_RESET = 32'h0000_0000;
  localparam logic GIO_FLAG_RESET = 1'b0;
  localparam logic [31:0] GIO_MASK_000 = 32'h7FFF_FFFF;
  localparam logic [31:0] GIO_MASK_040 = 32'h7FFF_FFFF;
  localparam logic [31:0] GIO_MASK_100 = 32'h07FF_FFFF;
  localparam logic [31:0] GIO_MASK_140 = 32'h001F_FFFF;
  localparam logic [31:0] GIO_MASK_200 = 32'h0000_FFFF;
  localparam logic [4:0][31:0] GIO_LINE_MASK = {GIO_MASK_200,
    GIO_MASK_140, GIO_MASK_100, GIO_MASK_040, GIO_MASK_000};

endpackage

// ---- gio_slice.sv ----
`timescale 1ns/100ps
module gio_slice #(
  parameter logic [31:0] LINE_MASK = 32'hFFFF_FFFF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] pad_in,
  input wire logic [31:0] out_val,
  input wire logic [31:0] alt_we,
  input wire logic [31:0] alt_data,
  input wire logic [31:0] mux_sel,
  input wire logic [31:0] polarity,
  input wire logic [31:0] alt_sig,
  output logic [31:0] pad_level,
  output logic [31:0] pad_drive
);
  import gio_pkg::*;

  // ---------------------------------------------------------------
  // input synchroniser
  // ---------------------------------------------------------------
  logic [31:0] meta_r;
  logic [31:0] sync_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= GIO_RESET;
      sync_r <= GIO_RESET;
    end else begin
      meta_r <= pad_in;
      sync_r <= meta_r;
    end
  end

  assign pad_level = sync_r & LINE_MASK;

  // ---------------------------------------------------------------
  // output selection
  // ---------------------------------------------------------------
  wire [31:0] gpio_val = (alt_we & alt_data) | (~alt_we & out_val);
  wire [31:0] alt_val = alt_sig ^ polarity;
  wire [31:0] drive_nxt = ((mux_sel & alt_val) | (~mux_sel & gpio_val))
    & LINE_MASK;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad_drive <= GIO_RESET;
    end else begin
      pad_drive <= drive_nxt;
    end
  end

endmodule // gio_slice

// ---- gio_top.sv ----
`timescale 1ns/100ps
module gio_top (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [gio_pkg::GIO_ADDR_W-1:0] PB_ADDR,
  input wire logic PB_WR,
  input wire logic PB_RD,
  input wire logic [31:0] PB_WDATA,
  output logic [31:0] PB_RDATA,
  output logic PB_ACK,
  input wire logic [gio_pkg::GIO_LINES-1:0] PAD_IN,
  input wire logic [gio_pkg::GIO_LINES-1:0] ALT_SIG,
  output logic [gio_pkg::GIO_LINES-1:0] PAD_OUT
);
  import gio_pkg::*;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire [6:0] blk = PB_ADDR[11:5];
  wire [2:0] grp = PB_ADDR[4:2];
  wire aligned = (PB_ADDR[1:0] == 2'h0);
  wire grp_ok = aligned && (grp < 3'(GIO_GROUPS));
  wire [2:0] gi = grp_ok ? grp : 3'h0;
  wire [4:0] grp_hot = grp_ok ? 5'(5'h01 << grp) : 5'h00;

  wire hit_we = (blk == GIO_ALT_WE_BASE[11:5]);
  wire hit_data = (blk == GIO_ALT_DATA_BASE[11:5]);
  wire hit_mux = (blk == GIO_MUX_BASE[11:5]);
  wire hit_pol = (blk == GIO_POL_BASE[11:5]);
  wire hit_out = (blk == GIO_OUT_BASE[11:5]);
  wire hit_in = (blk == GIO_IN_BASE[11:5]);
  wire hit_any = grp_ok &&
    (hit_we || hit_data || hit_mux || hit_pol || hit_out || hit_in);

  wire [4:0] wr_we = (PB_WR && hit_we) ? grp_hot : 5'h00;
  wire [4:0] wr_data = (PB_WR && hit_data) ? grp_hot : 5'h00;
  wire [4:0] wr_mux = (PB_WR && hit_mux) ? grp_hot : 5'h00;
  wire [4:0] wr_pol = (PB_WR && hit_pol) ? grp_hot : 5'h00;
  wire [4:0] wr_out = (PB_WR && hit_out) ? grp_hot : 5'h00;
  wire [4:0] wr_in = (PB_WR && hit_in) ? grp_hot : 5'h00;

  // ---------------------------------------------------------------
  // group registers
  // ---------------------------------------------------------------
  logic [31:0] out_r [GIO_GROUPS];
  logic [31:0] alt_we_r [GIO_GROUPS];
  logic [31:0] alt_data_r [GIO_GROUPS];
  logic [31:0] mux_r [GIO_GROUPS];
  logic [31:0] pol_r [GIO_GROUPS];
  logic [GIO_GROUPS-1:0] flag_r;
  logic [31:0] level [GIO_GROUPS];

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int g = 0; g < GIO_GROUPS; g++) begin
        out_r[g] <= GIO_RESET;
        alt_we_r[g] <= GIO_RESET;
        alt_data_r[g] <= GIO_RESET;
        mux_r[g] <= GIO_RESET;
        pol_r[g] <= GIO_RESET;
        flag_r[g] <= GIO_FLAG_RESET;
      end
    end else begin
      for (int g = 0; g < GIO_GROUPS; g++) begin
        if (wr_out[g]) begin
          out_r[g] <= PB_WDATA & GIO_LINE_MASK[g];
        end
        if (wr_we[g]) begin
          alt_we_r[g] <= PB_WDATA & GIO_LINE_MASK[g];
        end
        if (wr_data[g]) begin
          alt_data_r[g] <= PB_WDATA & GIO_LINE_MASK[g];
        end
        if (wr_mux[g]) begin
          mux_r[g] <= PB_WDATA & GIO_LINE_MASK[g];
        end
        if (wr_pol[g]) begin
          pol_r[g] <= PB_WDATA & GIO_LINE_MASK[g];
        end
        if (wr_in[g]) begin
          flag_r[g] <= PB_WDATA[GIO_FLAG_BIT];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // per-group pad logic
  // ---------------------------------------------------------------
  for (genvar g = 0; g < GIO_GROUPS; g++) begin : g_slice
    gio_slice #(
      .LINE_MASK(GIO_LINE_MASK[g])
    ) u_slice (
      .clk(CLK),
      .rstn(RSTN),
      .pad_in(PAD_IN[g*GIO_WIDTH +: GIO_WIDTH]),
      .out_val(out_r[g]),
      .alt_we(alt_we_r[g]),
      .alt_data(alt_data_r[g]),
      .mux_sel(mux_r[g]),
      .polarity(pol_r[g]),
      .alt_sig(ALT_SIG[g*GIO_WIDTH +: GIO_WIDTH]),
      .pad_level(level[g]),
      .pad_drive(PAD_OUT[g*GIO_WIDTH +: GIO_WIDTH])
    );
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire [31:0] in_val = {flag_r[gi], level[gi][30:0]};
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (grp_ok) begin
      if (hit_in) begin
        rd_val = in_val;
      end else if (hit_out) begin
        rd_val = out_r[gi];
      end else if (hit_we) begin
        rd_val = alt_we_r[gi];
      end else if (hit_data) begin
        rd_val = alt_data_r[gi];
      end else if (hit_mux) begin
        rd_val = mux_r[gi];
      end else if (hit_pol) begin
        rd_val = pol_r[gi];
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PB_RDATA <= GIO_RESET;
      PB_ACK <= 1'b0;
    end else begin
      PB_RDATA <= PB_RD ? rd_val : GIO_RESET;
      PB_ACK <= PB_RD || PB_WR;
    end
  end

endmodule // gio_top

// ---- gio_top_props.sv ----
`timescale 1ns/100ps
module gio_top_props (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [11:0] PB_ADDR,
  input wire logic PB_WR,
  input wire logic PB_RD,
  input wire logic [31:0] PB_WDATA,
  input wire logic [31:0] PB_RDATA,
  input wire logic PB_ACK,
  input wire logic [159:0] PAD_IN,
  input wire logic [159:0] ALT_SIG,
  input wire logic [159:0] PAD_OUT
);
  import gio_pkg::*;
  // ----
  // checks
  // ----
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property p_ack; PB_WR || PB_RD |=> PB_ACK; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_idle; !(PB_WR || PB_RD) |=> !PB_ACK && PB_RDATA == 0;
  endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_resv; (PAD_OUT & ~GIO_LINE_MASK) == 0; endproperty
  a_resv: assert property (p_resv) else $error("reserved driven");
  property p_out; PB_WR && PB_ADDR == 12'h280 |=> ##1
    PAD_OUT[31:0] == ($past(PB_WDATA, 2) & GIO_MASK_000); endproperty
  a_out: assert property (p_out) else $error("out level");
  property p_in; PB_RD && PB_ADDR == 12'h300 && $past(RSTN, 2) &&
    $stable(PAD_IN[30:0]) && PAD_IN[30:0] == $past(PAD_IN[30:0], 2)
    |=> PB_RDATA[30:0] == $past(PAD_IN[30:0]); endproperty
  a_in: assert property (p_in) else $error("in level");
  property p_flag; PB_WR && !PB_RD && PB_ADDR == 12'h300 ##1 !PB_WR
    ##1 PB_RD && !PB_WR && PB_ADDR == 12'h300
    |=> PB_RDATA[31] == $past(PB_WDATA[31], 3); endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_unm; PB_RD && PB_ADDR == 12'h3FC |=> PB_RDATA == 0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
  property p_hold; !$past(PB_WR) && $stable(ALT_SIG) |=> $stable(PAD_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("out moved");
endmodule // gio_top_props
bind gio_top gio_top_props i_props (.CLK(CLK), .RSTN(RSTN),
  .PB_ADDR(PB_ADDR), .PB_WR(PB_WR), .PB_RD(PB_RD), .PB_WDATA(PB_WDATA),
  .PB_RDATA(PB_RDATA), .PB_ACK(PB_ACK), .PAD_IN(PAD_IN),
  .ALT_SIG(ALT_SIG), .PAD_OUT(PAD_OUT));

// ---- gio_pads.sv ----
`timescale 1ns/100ps
module gio_pads (
  input wire logic [159:0] drive,
  output logic [159:0] level
);
  // ----
  // pad buffers return the driven level
  // ----
  assign level = drive;
endmodule // gio_pads

// ---- gio_group_input_output_bench.sv ----
`timescale 1ns/100ps
module gio_group_input_output_bench;
  import gio_pkg::*;
  // ----
  // bench
  // ----
  logic CLK = 0, RSTN = 0, PB_WR = 0, PB_RD = 0, PB_ACK;
  logic [11:0] PB_ADDR = 0;
  logic [31:0] PB_WDATA = 0, PB_RDATA;
  logic [159:0] PAD_IN, ALT_SIG = 0, PAD_OUT;
  int num_errors = 0, n_tests = 0;
  always #50 CLK = ~CLK;
  gio_top i_dut (.CLK(CLK), .RSTN(RSTN), .PB_ADDR(PB_ADDR), .PB_WR(PB_WR),
    .PB_RD(PB_RD), .PB_WDATA(PB_WDATA), .PB_RDATA(PB_RDATA),
    .PB_ACK(PB_ACK), .PAD_IN(PAD_IN), .ALT_SIG(ALT_SIG), .PAD_OUT(PAD_OUT));
  gio_pads i_pads (.drive(PAD_OUT), .level(PAD_IN));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] e);
    @(posedge CLK);
    PB_WR <= w;
    PB_RD <= !w;
    PB_ADDR <= a;
    PB_WDATA <= d;
    @(posedge CLK);
    PB_WR <= 0;
    PB_RD <= 0;
    #1 chk({31'h0, PB_ACK}, 32'h1);
    if (!w) chk(PB_RDATA, e);
  endtask
  task automatic pad(input int g, input logic [31:0] e);
    repeat (4) @(posedge CLK);
    #1 chk(PAD_OUT[32*g+:32], e);
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge CLK);
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (3) @(posedge CLK);
    RSTN <= 1;
    acc(0, GIO_OUT_BASE, 0, 0);
    acc(0, GIO_IN_BASE, 0, 0);
    for (int g = 0; g < 5; g++) begin
      acc(1, GIO_OUT_BASE + 12'(4 * g), 32'hFFFF_FFFF, 0);
      acc(0, GIO_OUT_BASE + 12'(4 * g), 0, GIO_LINE_MASK[g]);
      pad(g, GIO_LINE_MASK[g]);
      acc(0, GIO_IN_BASE + 12'(4 * g), 0, GIO_LINE_MASK[g]);
    end
    $display("test groups done");
    acc(1, 12'h288, 32'h4, 0);
    pad(2, 32'h4);
    acc(0, GIO_IN_100_OFS, 0, 32'h4);
    acc(1, 12'h300, 32'hFFFF_FFFF, 0);
    acc(0, 12'h300, 0, 32'hFFFF_FFFF);
    acc(1, 12'h300, 0, 0);
    acc(0, 12'h300, 0, 32'h7FFF_FFFF);
    $display("test flag done");
    acc(1, 12'h260, 32'hFFFF_FFFF, 0);
    acc(1, 12'h280, 32'h5, 0);
    pad(0, 32'h5);
    acc(1, 12'h204, 32'h1, 0);
    acc(1, 12'h284, 32'h3, 0);
    pad(1, 32'h2);
    acc(1, 12'h224, 32'h1, 0);
    pad(1, 32'h3);
    acc(1, 12'h284, 32'h0, 0);
    pad(1, 32'h1);
    acc(1, 12'h24C, 32'h1, 0);
    pad(3, 32'h001F_FFFE);
    acc(0, 12'h30C, 0, 32'h001F_FFFE);
    acc(1, 12'h26C, 32'h1, 0);
    pad(3, 32'h001F_FFFF);
    @(posedge CLK);
    ALT_SIG[96] <= 1'b1;
    pad(3, 32'h001F_FFFE);
    $display("test per pin done");
    acc(0, 12'h3FC, 0, 0);
    acc(1, 12'h281, 32'hFFFF_FFFF, 0);
    acc(0, 12'h280, 0, 32'h5);
    $display("test unmapped done");
    acc(0, 12'h280, 0, 32'h5);
    acc(1, 12'h280, PB_RDATA | 32'h2, 0);
    acc(0, 12'h300, 0, 32'h5);
    acc(0, 12'h300, 0, 32'h7);
    pad(0, 32'h7);
    $display("test merge done");
    end_of_test;
  end
endmodule // gio_group_input_output_bench
